// File: rtl/lcwp_defines.svh
// timing counts, gain codes and range constants for the weight processor
`ifndef LCWP_DEFINES_SVH
`define LCWP_DEFINES_SVH
`define LCWP_CLK_HZ          20000000
`define LCWP_AGC_PERIOD_S    5
`define LCWP_AGC_CYCLES      (`LCWP_AGC_PERIOD_S * `LCWP_CLK_HZ)
`define LCWP_AVG_COUNT       244
`define LCWP_OSR             2048
`define LCWP_POST_GAIN_X8    2'h3
`define LCWP_PRE_X1          3'h0
`define LCWP_PRE_X8          3'h4
`define LCWP_PRE_CODES       5
`define LCWP_OFS_ZERO        5'h10
`define LCWP_OFS_MAX         5'h1e
`define LCWP_AD_FULL         24'h7fffff
`define LCWP_AD_LOW_QTR      24'h200000
`define LCWP_AD_HIGH_QTR     24'h600000
`define LCWP_DIV_STEPS       32
`endif

// File: rtl/lcwp_pkg.sv
// types shared by the weight processor files
`default_nettype none
package lcwp_pkg;
    typedef struct packed {
        logic [2:0] pre_gain;
        logic [1:0] post_gain;
        logic [4:0] offset_code;
        logic       osr_max;
        logic       open_detect;
    } lcwp_fe_cfg_t;
    typedef struct packed {
        logic range_err;
        logic overflow_err;
        logic disconnect_err;
    } lcwp_err_t;
    typedef struct packed {
        logic signed [23:0] boundary;
        logic signed [23:0] intercept_lo;
        logic signed [23:0] slope_lo;
        logic signed [23:0] intercept_hi;
        logic signed [23:0] slope_hi;
    } lcwp_coef_t;
    typedef enum logic [2:0] {
        LCWP_IDLE, LCWP_RANGE_ADJ, LCWP_CAL_PT, LCWP_STORE, LCWP_MEASURE
    } lcwp_state_t;
endpackage
`default_nettype wire

// File: rtl/lcwp_divider.sv
// sequential signed restoring divider, one quotient bit per clock
`default_nettype none
`include "lcwp_defines.svh"
module lcwp_divider (
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    // request
    input  wire logic               start,
    input  wire logic signed [31:0] dividend,
    input  wire logic signed [23:0] divisor,
    // answer
    output logic                    done,
    output logic signed [31:0]      quotient
);
    logic [31:0] rem, next_rem, quo, next_quo;
    logic [23:0] dvs, next_dvs;
    logic [5:0]  cnt, next_cnt;
    logic        neg, next_neg, busy, next_busy, next_done;
    logic signed [31:0] next_quotient;
    logic [32:0] trial;

    always_comb begin
        next_rem = rem;
        next_quo = quo;
        next_dvs = dvs;
        next_cnt = cnt;
        next_neg = neg;
        next_busy = busy;
        next_done = 1'b0;
        next_quotient = quotient;
        trial = 33'h0;
        if (start && !busy) begin
            next_rem = 32'h0;
            next_quo = dividend[31] ? 32'(-dividend) : dividend;
            next_dvs = divisor[23] ? 24'(-divisor) : divisor;
            next_neg = dividend[31] ^ divisor[23];
            next_cnt = 6'h0;
            next_busy = 1'b1;
        end else if (busy) begin
            trial = {rem, quo[31]} - {9'h0, dvs};
            if (!trial[32]) begin
                next_rem = trial[31:0];
                next_quo = {quo[30:0], 1'b1};
            end else begin
                next_rem = {rem[30:0], quo[31]};
                next_quo = {quo[30:0], 1'b0};
            end
            next_cnt = cnt + 6'h1;
            if (cnt == 6'(`LCWP_DIV_STEPS - 1)) begin
                next_busy = 1'b0;
                next_done = 1'b1;
                // zero slope would be nonsense; answer zero rather than saturate
                next_quotient = (dvs == 24'h0) ? 32'h0 : (neg ? 32'(-next_quo) : next_quo);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rem <= 32'h0;
            quo <= 32'h0;
            dvs <= 24'h0;
            cnt <= 6'h0;
            neg <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            quotient <= 32'h0;
        end else begin
            rem <= next_rem;
            quo <= next_quo;
            dvs <= next_dvs;
            cnt <= next_cnt;
            neg <= next_neg;
            busy <= next_busy;
            done <= next_done;
            quotient <= next_quotient;
        end
    end
endmodule
`default_nettype wire

// File: rtl/lcwp_top.sv
// load cell weight processor: gain control, calibration, conversion, tare and errors
// Notes on behaviour
// - preamp gain codes x1,x2,x3,x4,x8; post gain codes x1,x2,x4,x8.
// - post gain always held at x8; only preamp gain changes.
// - preamp gain re-evaluated every 5 seconds to fill converter range.
// - an overflowing sample steps gain down once its averaging window ends.
// - range adjust sets offset converter so input stays within range.
// - calibrate once with reference loads; afterwards reuse stored results.
// - after calibration, write offset and coefficients to nonvolatile storage.
// - each segment slope and intercept come from two weight/sample points.
// - lower segment below boundary sample, else higher segment.
// - weight equals sample minus intercept, divided by slope.
// - zero adjust captures tare and subtracts it from later results.
// - range error when load exceeds the sensor range.
// - overflow error when a converter sample overflows.
// - disconnect check enables a tiny current source at amplifier input.
// - disconnect error, with disconnect check enabled, on range or overflow error during measurement.
// - offset converter spans -164 to +164 mV with 5-bit code.
// - converter runs at oversampling 2048, about 488.28 samples per second.
// - average 244 consecutive samples before weight conversion.
`default_nettype none
`include "lcwp_defines.svh"
module lcwp_top #(
    parameter int AGC_CYCLES = `LCWP_AGC_CYCLES
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    // front end samples
    input  wire logic                 sample_valid,
    input  wire logic signed [23:0]   sample_data,
    input  wire logic                 sample_overflow,
    // front end settings
    output lcwp_pkg::lcwp_fe_cfg_t    fe_cfg,
    // commands
    input  wire logic                 cal_valid_flag,
    input  wire logic                 range_adj_req,
    input  wire logic                 cal_point_req,
    input  wire logic signed [23:0]   cal_point_grams,
    input  wire logic                 cal_finish_req,
    input  wire logic                 zero_adj_req,
    input  wire logic signed [31:0]   max_grams,
    input  wire logic                 open_detect_en,
    // stored calibration
    input  wire lcwp_pkg::lcwp_coef_t stored_coef,
    input  wire logic [4:0]           stored_offset,
    output lcwp_pkg::lcwp_coef_t      nv_coef,
    output logic [4:0]                nv_offset,
    output logic                      nv_write,
    // results
    output logic signed [31:0]        weight,
    output logic signed [23:0]        avg_sample,
    output logic                      weight_valid,
    output lcwp_pkg::lcwp_err_t       err,
    output logic                      busy
);
    import lcwp_pkg::*;

    // slope held as counts per gram, so one divide per window suffices
    function automatic logic signed [23:0] seg_slope(input logic signed [23:0] s1, s0, g1, g0);
        logic signed [23:0] dg;
        dg = g1 - g0;
        seg_slope = (dg == 24'sh0) ? 24'sh1 : 24'((s1 - s0) / dg);
    endfunction

    function automatic logic signed [23:0] seg_icpt(input logic signed [23:0] s0, g0, sl);
        seg_icpt = 24'(s0 - sl * g0);
    endfunction

    lcwp_state_t        state, next_state;
    lcwp_fe_cfg_t       next_fe_cfg;
    lcwp_coef_t         coef, next_coef, next_nv_coef;
    logic [4:0]         next_nv_offset;
    logic               next_nv_write, next_busy, next_weight_valid;
    lcwp_err_t          next_err;
    logic signed [31:0] acc, next_acc, tare, next_tare, next_weight;
    logic [7:0]         nsamp, next_nsamp;
    logic               win_ovf, next_win_ovf;
    logic signed [23:0] next_avg_sample;
    logic [31:0]        agc_cnt, next_agc_cnt;
    logic signed [23:0] pt_s [3], next_pt_s [3];
    logic signed [23:0] pt_g [3], next_pt_g [3];
    logic [1:0]         npts, next_npts;
    logic               tare_pend, next_tare_pend, ovf_pend, next_ovf_pend;
    logic               div_start, next_div_start, div_done;
    logic               win_ovf_last, next_win_ovf_last;
    logic signed [31:0] div_q;
    logic signed [31:0] dividend;
    logic signed [23:0] divisor;
    logic               use_hi;

    // signed copies, so the auto-gain bands compare as signed values
    localparam logic signed [23:0] LOW_QTR  = `LCWP_AD_LOW_QTR;
    localparam logic signed [23:0] HIGH_QTR = `LCWP_AD_HIGH_QTR;
    assign use_hi = !(avg_sample < coef.boundary);
    assign dividend = 32'(avg_sample) - 32'(use_hi ? coef.intercept_hi : coef.intercept_lo);
    assign divisor = use_hi ? coef.slope_hi : coef.slope_lo;

    lcwp_divider u_div (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .start    (div_start),
        .dividend (dividend),
        .divisor  (divisor),
        .done     (div_done),
        .quotient (div_q)
    );

    always_comb begin
        next_state = state;
        next_fe_cfg = fe_cfg;
        next_fe_cfg.post_gain = `LCWP_POST_GAIN_X8;
        next_fe_cfg.osr_max = 1'b1;
        next_fe_cfg.open_detect = open_detect_en;
        next_coef = coef;
        next_nv_coef = nv_coef;
        next_nv_offset = nv_offset;
        next_nv_write = 1'b0;
        next_busy = (state != LCWP_MEASURE);
        next_weight_valid = 1'b0;
        next_err = err;
        next_acc = acc;
        next_nsamp = nsamp;
        next_win_ovf = win_ovf;
        next_avg_sample = avg_sample;
        next_tare = tare;
        next_weight = weight;
        next_agc_cnt = agc_cnt;
        next_pt_s = pt_s;
        next_pt_g = pt_g;
        next_npts = npts;
        next_tare_pend = tare_pend | zero_adj_req;
        next_ovf_pend = 1'b0;
        next_div_start = 1'b0;
        if (sample_valid) begin
            next_acc = acc + 32'(sample_data);
            next_nsamp = nsamp + 8'h1;
            next_win_ovf = win_ovf | sample_overflow;
            if (nsamp == 8'(`LCWP_AVG_COUNT - 1)) begin
                next_acc = 32'sh0;
                next_nsamp = 8'h0;
                next_win_ovf = 1'b0;
                next_avg_sample = 24'((acc + 32'(sample_data)) / `LCWP_AVG_COUNT);
                next_ovf_pend = win_ovf | sample_overflow;
                // launch a cycle late, once avg_sample holds this window
                next_div_start = (state == LCWP_MEASURE);
            end
        end
        unique case (state)
            LCWP_IDLE: begin
                if (cal_valid_flag) begin
                    next_coef = stored_coef;
                    next_fe_cfg.offset_code = stored_offset;
                    next_state = LCWP_MEASURE;
                end else if (range_adj_req) begin
                    next_fe_cfg.offset_code = `LCWP_OFS_ZERO;
                    next_fe_cfg.pre_gain = `LCWP_PRE_X1;
                    next_state = LCWP_RANGE_ADJ;
                end
            end
            LCWP_RANGE_ADJ: begin
                // on an overflowing window, step the 5-bit code against the sign of the average, one step per window
                if (ovf_pend) begin
                    if (avg_sample > 24'sh0 && fe_cfg.offset_code != 5'h0)
                        next_fe_cfg.offset_code = fe_cfg.offset_code - 5'h1;
                    else if (avg_sample <= 24'sh0 && fe_cfg.offset_code != `LCWP_OFS_MAX)
                        next_fe_cfg.offset_code = fe_cfg.offset_code + 5'h1;
                end else if (sample_valid && nsamp == 8'(`LCWP_AVG_COUNT - 1) && !(win_ovf | sample_overflow)) begin
                    next_state = LCWP_CAL_PT;
                    next_npts = 2'h0;
                end
            end
            LCWP_CAL_PT: begin
                if (cal_point_req && npts != 2'h3) begin
                    next_pt_s[npts] = avg_sample;
                    next_pt_g[npts] = cal_point_grams;
                    next_npts = npts + 2'h1;
                end else if (cal_finish_req && npts >= 2'h2) begin
                    next_coef.slope_lo = seg_slope(pt_s[1], pt_s[0], pt_g[1], pt_g[0]);
                    next_coef.intercept_lo = seg_icpt(pt_s[0], pt_g[0], next_coef.slope_lo);
                    next_coef.boundary = (npts == 2'h3) ? pt_s[1] : 24'sh7fffff;
                    if (npts == 2'h3) begin
                        next_coef.slope_hi = seg_slope(pt_s[2], pt_s[1], pt_g[2], pt_g[1]);
                        next_coef.intercept_hi = seg_icpt(pt_s[1], pt_g[1], next_coef.slope_hi);
                    end else begin
                        next_coef.slope_hi = next_coef.slope_lo;
                        next_coef.intercept_hi = next_coef.intercept_lo;
                    end
                    next_state = LCWP_STORE;
                end
            end
            LCWP_STORE: begin
                next_nv_coef = coef;
                next_nv_offset = fe_cfg.offset_code;
                next_nv_write = 1'b1;
                next_state = LCWP_MEASURE;
            end
            LCWP_MEASURE: begin
                next_agc_cnt = agc_cnt + 32'h1;
                if (ovf_pend && fe_cfg.pre_gain != `LCWP_PRE_X1) begin
                    next_fe_cfg.pre_gain = fe_cfg.pre_gain - 3'h1;
                end else if (agc_cnt >= 32'(AGC_CYCLES - 1)) begin
                    next_agc_cnt = 32'h0;
                    if ((avg_sample < LOW_QTR && avg_sample > -LOW_QTR)
                            && fe_cfg.pre_gain != `LCWP_PRE_X8)
                        next_fe_cfg.pre_gain = fe_cfg.pre_gain + 3'h1;
                    else if ((avg_sample > HIGH_QTR || avg_sample < -HIGH_QTR)
                            && fe_cfg.pre_gain != `LCWP_PRE_X1)
                        next_fe_cfg.pre_gain = fe_cfg.pre_gain - 3'h1;
                end
                if (div_done) begin
                    if (tare_pend) begin
                        next_tare = div_q;
                        next_tare_pend = zero_adj_req;
                        next_weight = 32'sh0;
                    end else begin
                        next_weight = div_q - tare;
                    end
                    next_err.range_err = (div_q > max_grams) || (div_q < -max_grams);
                    next_err.overflow_err = win_ovf_last;
                    next_err.disconnect_err = open_detect_en &&
                        (((div_q > max_grams) || (div_q < -max_grams)) || win_ovf_last);
                    next_weight_valid = 1'b1;
                end
            end
            default: next_state = LCWP_IDLE;
        endcase
    end

    always_comb begin
        next_win_ovf_last = ovf_pend ? 1'b1 : (div_done ? 1'b0 : win_ovf_last);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= LCWP_IDLE;
            fe_cfg <= '{pre_gain: `LCWP_PRE_X1, post_gain: `LCWP_POST_GAIN_X8,
                        offset_code: `LCWP_OFS_ZERO, osr_max: 1'b1, open_detect: 1'b0};
            coef <= '0;
            nv_coef <= '0;
            nv_offset <= 5'h0;
            nv_write <= 1'b0;
            busy <= 1'b1;
            weight_valid <= 1'b0;
            err <= '0;
            acc <= 32'sh0;
            nsamp <= 8'h0;
            win_ovf <= 1'b0;
            avg_sample <= 24'sh0;
            tare <= 32'sh0;
            weight <= 32'sh0;
            agc_cnt <= 32'h0;
            pt_s <= '{default: 24'sh0};
            pt_g <= '{default: 24'sh0};
            npts <= 2'h0;
            tare_pend <= 1'b0;
            ovf_pend <= 1'b0;
            win_ovf_last <= 1'b0;
            div_start <= 1'b0;
        end else begin
            state <= next_state;
            fe_cfg <= next_fe_cfg;
            coef <= next_coef;
            nv_coef <= next_nv_coef;
            nv_offset <= next_nv_offset;
            nv_write <= next_nv_write;
            busy <= next_busy;
            weight_valid <= next_weight_valid;
            err <= next_err;
            acc <= next_acc;
            nsamp <= next_nsamp;
            win_ovf <= next_win_ovf;
            avg_sample <= next_avg_sample;
            tare <= next_tare;
            weight <= next_weight;
            agc_cnt <= next_agc_cnt;
            pt_s <= next_pt_s;
            pt_g <= next_pt_g;
            npts <= next_npts;
            tare_pend <= next_tare_pend;
            ovf_pend <= next_ovf_pend;
            win_ovf_last <= next_win_ovf_last;
            div_start <= next_div_start;
        end
    end
endmodule
`default_nettype wire

// File: verification/lcwp_monitor.sv
// port assertions for the weight processor, bound to its top
`default_nettype none
module lcwp_monitor #(
    parameter int AGC_CYCLES = 2000
) (
    // clock and reset
    input wire logic                   ref_clk,
    input wire logic                   rstn,
    // observed
    input wire logic                   sample_valid,
    input wire lcwp_pkg::lcwp_fe_cfg_t fe_cfg,
    input wire logic                   open_detect_en,
    input wire logic                   nv_write,
    input wire logic signed [31:0]     weight,
    input wire logic                   weight_valid,
    input wire lcwp_pkg::lcwp_err_t    err,
    input wire logic                   busy
);
    import lcwp_pkg::*;
    // samples of the open window, counted only while measuring
    logic [7:0] win_cnt;
    logic [7:0] next_win_cnt;
    always_comb begin
        next_win_cnt = win_cnt;
        if (busy) begin
            next_win_cnt = 8'h00;
        end else if (sample_valid) begin
            next_win_cnt = (win_cnt == 8'hf3) ? 8'h00 : win_cnt + 8'h01;
        end
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            win_cnt <= 8'h00;
        end else begin
            win_cnt <= next_win_cnt;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    property p_post_gain; fe_cfg.post_gain == 2'h3 && fe_cfg.osr_max; endproperty
    a_post_gain: assert property (p_post_gain) else $error("post gain or ratio moved");
    property p_pre_code; fe_cfg.pre_gain <= 3'h4; endproperty
    a_pre_code: assert property (p_pre_code) else $error("bad preamp code");
    property p_gain_step; $changed(fe_cfg.pre_gain) |-> fe_cfg.pre_gain == $past(fe_cfg.pre_gain) + 3'h1
        || fe_cfg.pre_gain + 3'h1 == $past(fe_cfg.pre_gain); endproperty
    a_gain_step: assert property (p_gain_step) else $error("gain jumped");
    property p_offset; fe_cfg.offset_code <= 5'h1e; endproperty
    a_offset: assert property (p_offset) else $error("offset code out of span");
    property p_open_detect; fe_cfg.open_detect == $past(open_detect_en); endproperty
    a_open_detect: assert property (p_open_detect) else $error("detect source not following");
    property p_result_time; sample_valid && !busy && win_cnt == 8'hf3 |-> ##[33:35] weight_valid; endproperty
    a_result_time: assert property (p_result_time) else $error("no result after window");
    property p_valid_pulse; weight_valid |-> !busy ##1 !weight_valid; endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("result pulse wrong");
    property p_hold; $changed(weight) || $changed(err) |-> weight_valid; endproperty
    a_hold: assert property (p_hold) else $error("result moved between windows");
    property p_disc; err.disconnect_err |-> err.range_err || err.overflow_err; endproperty
    a_disc: assert property (p_disc) else $error("disconnect without cause");
    property p_nv_write; nv_write |-> busy ##1 !nv_write; endproperty
    a_nv_write: assert property (p_nv_write) else $error("store pulse wrong");
endmodule
bind lcwp_top lcwp_monitor #(.AGC_CYCLES(AGC_CYCLES)) mon_u (.ref_clk(ref_clk), .rstn(rstn),
    .sample_valid(sample_valid), .fe_cfg(fe_cfg), .open_detect_en(open_detect_en), .nv_write(nv_write),
    .weight(weight), .weight_valid(weight_valid), .err(err), .busy(busy));
`default_nettype wire

// File: verification/lcwp_fe_model.sv
// behavioural front end: bursts of 244 samples on request
`default_nettype none
module lcwp_fe_model (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    // bench control
    input  wire logic                   go,
    input  wire logic signed [23:0]     level,
    input  wire logic                   fault,
    input  wire logic                   broken,
    // settings and samples
    input  wire lcwp_pkg::lcwp_fe_cfg_t fe_cfg,
    output logic                        sample_valid,
    output logic signed [23:0]          sample_data,
    output logic                        sample_overflow
);
    import lcwp_pkg::*;
    logic [7:0] left;
    logic [1:0] ph;
    logic       ovf;
    // a broken wire only overflows once the detect source is on
    assign ovf = fault || (broken && fe_cfg.open_detect);
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            left <= 8'h00;
            ph <= 2'h0;
            sample_valid <= 1'b0;
            sample_data <= 24'h000000;
            sample_overflow <= 1'b0;
        end else begin
            ph <= go ? 2'h0 : ph + 2'h1;
            sample_valid <= 1'b0;
            // junk between samples so stale data never looks valid
            sample_data <= ~sample_data;
            sample_overflow <= ~sample_overflow;
            if (go) begin
                left <= 8'hf4;
            end else if (left != 8'h00 && ph == 2'h3) begin
                left <= left - 8'h01;
                sample_valid <= 1'b1;
                sample_data <= ovf ? 24'h7fffff : level;
                sample_overflow <= ovf;
            end
        end
    end
endmodule
`default_nettype wire

// File: verification/lcwp_tb.sv
// testbench: calibration, stored coefficients, segments, errors and tare
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import lcwp_pkg::*;
    typedef struct {
        logic signed [31:0] w;
        logic signed [23:0] a;
        lcwp_err_t          e;
    } lcwp_note_t;
    logic               ref_clk = 1'b0;
    logic               rstn = 1'b0;
    logic               cal_valid_flag = 1'b0;
    logic               open_detect_en = 1'b0;
    logic [3:0]         cmd = 4'h0;
    logic signed [23:0] cal_point_grams = 24'h000000;
    logic signed [31:0] max_grams = 32'h00003e80;
    lcwp_coef_t         stored_coef = '{24'h100000, 24'h000800, 24'h000064, 24'h020000, 24'h000050};
    logic               fe_go = 1'b0;
    logic signed [23:0] fe_level = 24'h000000;
    logic               fe_fault = 1'b0;
    logic               fe_broken = 1'b0;
    logic               sample_valid, sample_overflow, nv_write, weight_valid, busy, tare_pend = 1'b0;
    logic signed [23:0] sample_data, avg_sample;
    logic signed [31:0] weight;
    logic [4:0]         nv_offset;
    lcwp_coef_t         nv_coef;
    logic [2:0]         g;
    lcwp_fe_cfg_t       fe_cfg;
    lcwp_err_t          err;
    lcwp_note_t         notes[$];
    lcwp_note_t         got;
    int                 miscompares = 0;
    int                 n_tests = 0;
    int                 tare = 0;
    int                 k;
    lcwp_top #(.AGC_CYCLES(3000)) dut_u (.ref_clk(ref_clk), .rstn(rstn), .sample_valid(sample_valid),
        .sample_data(sample_data), .sample_overflow(sample_overflow), .fe_cfg(fe_cfg),
        .cal_valid_flag(cal_valid_flag), .range_adj_req(cmd[3]), .cal_point_req(cmd[2]),
        .cal_point_grams(cal_point_grams), .cal_finish_req(cmd[1]), .zero_adj_req(cmd[0]),
        .max_grams(max_grams), .open_detect_en(open_detect_en), .stored_coef(stored_coef),
        .stored_offset(5'h10), .nv_coef(nv_coef), .nv_offset(nv_offset), .nv_write(nv_write), .weight(weight),
        .avg_sample(avg_sample), .weight_valid(weight_valid), .err(err), .busy(busy));
    lcwp_fe_model fe_u (.ref_clk(ref_clk), .rstn(rstn), .go(fe_go), .level(fe_level), .fault(fe_fault),
        .broken(fe_broken), .fe_cfg(fe_cfg), .sample_valid(sample_valid), .sample_data(sample_data),
        .sample_overflow(sample_overflow));
    initial forever #25 ref_clk = ~ref_clk;
    task automatic fail(input string m);
        miscompares++;
        $display("Error at %0t: %s", $time, m);
    endtask
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) fail(m);
    endtask
    task automatic conclude();
        $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    function automatic int raw_w(input int lv);
        if (lv < 32'h00100000) return (lv - 32'h00000800) / 32'h00000064;
        return (lv - 32'h00020000) / 32'h00000050;
    endfunction
    task automatic pulse(input int b);
        @(posedge ref_clk);
        cmd[b] <= 1'b1;
        @(posedge ref_clk);
        cmd <= 4'h0;
    endtask
    task automatic burst(input logic signed [23:0] lv, input logic flt, input logic brk);
        fe_level <= lv;
        fe_fault <= flt;
        fe_broken <= brk;
        fe_go <= 1'b1;
        @(posedge ref_clk);
        fe_go <= 1'b0;
        repeat (990) @(posedge ref_clk);
    endtask
    task automatic do_reset(input logic stored);
        rstn <= 1'b0;
        cal_valid_flag <= stored;
        repeat (20) @(posedge ref_clk);
        chk(fe_cfg === 12'h1c2 && busy === 1'b1, "reset outputs");
        rstn <= 1'b1;
    endtask
    task automatic wait_meas();
        for (k = 0; k < 200 && busy !== 1'b0; k++) @(posedge ref_clk);
        chk(busy === 1'b0, "measurement not entered");
    endtask
    // one averaging window; the expected result is queued before any sample goes out
    task automatic win(input logic signed [23:0] lv, input logic flt, input logic brk);
        lcwp_note_t n;
        logic       ovf;
        int         i;
        @(posedge ref_clk);
        ovf = flt || (brk && open_detect_en);
        n.a = ovf ? 24'h7fffff : lv;
        n.w = raw_w(n.a) - tare;
        if (tare_pend) begin
            tare = raw_w(n.a);
            tare_pend = 1'b0;
            n.w = 32'h00000000;
        end
        n.e.range_err = n.w > max_grams || n.w < -max_grams;
        n.e.overflow_err = ovf;
        n.e.disconnect_err = open_detect_en && (ovf || n.e.range_err);
        notes.push_back(n);
        burst(lv, flt, brk);
        for (i = 0; i < 200 && notes.size() > 0; i++) @(posedge ref_clk);
        chk(notes.size() == 0, "no result");
        notes.delete();
    endtask
    always @(posedge ref_clk) begin
        if (weight_valid === 1'b1) begin
            n_tests++;
            if (notes.size() == 0) fail("unexpected result");
            else begin
                got = notes.pop_front();
                if (weight !== got.w || avg_sample !== got.a || err !== got.e) fail("result mismatch");
            end
        end
    end
    initial begin
        void'($urandom(85312));
        do_reset(1'b0);
        pulse(3);
        burst(24'h100000, 1'b1, 1'b0);
        burst(24'h100000, 1'b0, 1'b0);
        pulse(2);
        cal_point_grams <= 24'h0001f4;
        burst(24'h300000, 1'b0, 1'b0);
        pulse(2);
        pulse(1);
        for (k = 0; k < 8 && nv_write !== 1'b1; k++) @(posedge ref_clk);
        chk(nv_write === 1'b1 && nv_offset === 5'h0f && nv_coef.slope_lo === 24'h001062
            && nv_coef.intercept_lo === 24'h100000, "calibration not stored");
        wait_meas();
        do_reset(1'b1);
        wait_meas();
        repeat (5) win(24'($urandom_range(32'h001fffff, 32'h00001000)), 1'b0, 1'b0);
        chk(fe_cfg.pre_gain !== 3'h0, "gain never raised");
        win(24'h0fffff, 1'b0, 1'b0);
        win(24'h100000, 1'b0, 1'b0);
        win(24'h400000, 1'b0, 1'b0);
        g = fe_cfg.pre_gain;
        win(24'h010000, 1'b1, 1'b0);
        chk(fe_cfg.pre_gain < g, "gain not lowered");
        open_detect_en <= 1'b1;
        win(24'h010000, 1'b0, 1'b1);
        win(24'h080000, 1'b0, 1'b0);
        open_detect_en <= 1'b0;
        tare_pend = 1'b1;
        pulse(0);
        win(24'($urandom_range(32'h000fffff, 32'h00001000)), 1'b0, 1'b0);
        win(24'($urandom_range(32'h000fffff, 32'h00001000)), 1'b0, 1'b0);
        conclude();
    end
    initial begin
        #2000000;
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire
